// ---- tcg_timer_clk_ctrl.sv ----
// timer count-input control: source select, sync, gating and prescaler behind apb
//
// Operation
// - With the source bit at 0 the timer counts from the internal clock at oscillator/2.
// - With the source bit at 1 the count input comes from the extended clock instead.
// - The prescale field divides the input: 11 gives 1:256, 10 gives 1:64, 01 gives 1:8, 00 1:1.
// - Extended clock with the sync bit at 1 is synchronised to the internal clock first.
// - Extended clock with the sync bit at 0 drives the counting path directly.
// - With the internal clock selected the sync bit has no effect.
// - With the internal clock selected the gate bit at 1 turns on gated accumulation.
// - With the gate bit at 0 counting does not depend on the gate input.
// - With the extended clock selected the gate bit is ignored.
// - Control bits 0, 3 and 7 always read as zero.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
module tcg_timer_clk_ctrl
  import tcg_pkg::*;
(
  input wire logic clk, // system clock, the oscillator
  input wire logic rst, // asynchronous reset, active high
  input wire tcg_apb_req_t apb_req, // apb request from the bus master
  output tcg_apb_rsp_t apb_rsp, // apb response
  input wire logic ext_clk_pin, // external timer clock pin
  input wire logic gate_pin, // timer gate pin
  output logic count_tick, // one-cycle pulse: advance the timer by one
  output logic gate_mode_active // gated accumulation in force
);

  typedef struct packed {
    tcg_ctrl_t ctrl;
    logic int_phase;
    logic ext_prev;
    logic ext_pend;
    logic [7:0] pcnt;
    logic tick;
    logic [15:0] ticks;
    logic [31:0] rdata;
    logic rd_err;
  } tcg_state_t;

  tcg_state_t st_q;
  tcg_state_t st_d;

  logic [1:0] pins_sync;
  logic ext_lvl;
  logic gate_lvl;

  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic int_en;
  logic ext_edge;
  logic src_tick;
  logic presc_last;
  logic gated;

  // terminal count of the prescaler for a given code
  function automatic logic [7:0] presc_top(input tcg_presc_t code);
    logic [7:0] top;
    top = 8'h00;
    unique case (code)
      TCG_PS_1: top = 8'(TCG_RATIO_1 - 1);
      TCG_PS_8: top = 8'(TCG_RATIO_8 - 1);
      TCG_PS_64: top = 8'(TCG_RATIO_64 - 1);
      TCG_PS_256: top = 8'(TCG_RATIO_256 - 1);
    endcase
    return top;
  endfunction : presc_top

  // address decode shared by write and error paths
  function automatic logic addr_mapped(input logic [11:0] addr);
    logic hit;
    hit = (addr == TCG_CTRL_OFF) || (addr == TCG_TICKS_OFF) || (addr == TCG_STAT_OFF);
    return hit;
  endfunction : addr_mapped

  // control register as seen by software
  function automatic logic [31:0] ctrl_word(input tcg_ctrl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[TCG_CLK_SRC_BIT] = c.clock_source_select;
    w[TCG_SYNC_BIT] = c.external_clock_sync_select;
    w[TCG_PRESC_LO_BIT +: 2] = c.input_prescale_select;
    w[TCG_GATE_BIT] = c.gated_accumulation_enable;
    return w;
  endfunction : ctrl_word

  tcg_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .async_in({gate_pin, ext_clk_pin}),
    .sync_out(pins_sync)
  );

  assign ext_lvl = pins_sync[0];
  assign gate_lvl = pins_sync[1];

  // apb phases; the slave never inserts wait states
  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign wr_en = access_ph && apb_req.pwrite && addr_mapped(apb_req.paddr);

  // internal clock enable at oscillator/2
  assign int_en = st_q.int_phase;

  assign ext_edge = ext_lvl && !st_q.ext_prev;

  // gating applies only on the internal source
  assign gated = !st_q.ctrl.clock_source_select
                 && st_q.ctrl.gated_accumulation_enable;

  // count source selection
  always_comb begin
    src_tick = 1'b0;
    if (!st_q.ctrl.clock_source_select) begin
      // sync bit is not looked at on this path
      if (gated) begin
        src_tick = int_en && gate_lvl;
      end else begin
        src_tick = int_en;
      end
    end else if (st_q.ctrl.external_clock_sync_select) begin
      // edge waits for the internal clock phase
      src_tick = (st_q.ext_pend || ext_edge) && int_en;
    end else begin
      // no alignment to the internal clock: edge goes straight on
      src_tick = ext_edge;
    end
  end

  // the field picks the terminal count; >= would also end a count sitting above a
  // shorter terminal count, but a control write clears the count when the ratio changes
  assign presc_last = (st_q.pcnt >= presc_top(st_q.ctrl.input_prescale_select));

  // control fields taken from a written word; the unused positions are dropped here
  function automatic tcg_ctrl_t ctrl_from_word(input logic [7:0] w);
    tcg_ctrl_t c;
    c = '0;
    c.clock_source_select = w[TCG_CLK_SRC_BIT];
    c.external_clock_sync_select = w[TCG_SYNC_BIT];
    c.input_prescale_select = tcg_presc_t'(w[TCG_PRESC_LO_BIT +: 2]);
    c.gated_accumulation_enable = w[TCG_GATE_BIT];
    return c;
  endfunction : ctrl_from_word

  localparam tcg_ctrl_t CTRL_INIT = ctrl_from_word(TCG_CTRL_RESET);

  // status word: live view of the count path
  function automatic logic [31:0] stat_word(input tcg_state_t s, input logic g);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[TCG_STAT_EXT_BIT] = s.ctrl.clock_source_select;
    w[TCG_STAT_GATE_BIT] = g;
    w[TCG_STAT_PEND_BIT] = s.ext_pend;
    w[TCG_STAT_PCNT_LO +: 8] = s.pcnt;
    return w;
  endfunction : stat_word

  // read multiplexer; an unmapped address reads as zero
  function automatic logic [31:0] read_word(input logic [11:0] addr, input tcg_state_t s,
                                            input logic g);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (addr == TCG_CTRL_OFF) begin
      w = ctrl_word(s.ctrl);
    end else if (addr == TCG_TICKS_OFF) begin
      w = {16'h0000, s.ticks};
    end else if (addr == TCG_STAT_OFF) begin
      w = stat_word(s, g);
    end
    return w;
  endfunction : read_word

  // next pending flag of the synchronised path: an edge that arrives off the internal
  // phase waits for it; the edge detector keeps two rising edges at least two cycles apart
  function automatic logic pend_next(input logic sync_on, input logic edge_seen,
                                     input logic pend, input logic phase);
    logic p;
    p = pend;
    if (!sync_on) begin
      p = 1'b0;
    end else if (edge_seen && !phase) begin
      p = 1'b1;
    end else if (phase) begin
      p = 1'b0;
    end
    return p;
  endfunction : pend_next

  logic ctrl_wr;
  logic ext_sync_on;
  logic rd_fault;
  logic [31:0] rd_word;

  // only the control register is writable; the other words are read-only views
  assign ctrl_wr = wr_en && (apb_req.paddr == TCG_CTRL_OFF) && apb_req.pstrb[0];

  assign ext_sync_on = st_q.ctrl.clock_source_select
                       && st_q.ctrl.external_clock_sync_select;

  // read data is captured in the setup cycle so that it comes from a flip-flop
  assign rd_word = read_word(apb_req.paddr, st_q, gated);
  assign rd_fault = !addr_mapped(apb_req.paddr);

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;

    // free-running phase of the internal clock at oscillator/2
    st_d.int_phase = !st_q.int_phase;

    // edge detector history follows the synchronised pin
    st_d.ext_prev = ext_lvl;

    st_d.ext_pend = pend_next(ext_sync_on, ext_edge, st_q.ext_pend, int_en);

    // a control write restarts the prescaler so the new ratio starts from a clean
    // count; the tick that would fall in that cycle is dropped
    if (ctrl_wr) begin
      st_d.ctrl = ctrl_from_word(apb_req.pwdata[7:0]);
      st_d.pcnt = 8'h00;
    end else if (src_tick) begin
      if (presc_last) begin
        st_d.pcnt = 8'h00;
        st_d.tick = 1'b1;
      end else begin
        st_d.pcnt = st_q.pcnt + 8'h01;
      end
    end

    // running count of delivered ticks; wraps silently at 16 bits
    st_d.ticks = st_q.ticks + {15'h0000, st_q.tick};

    if (setup_ph) begin
      st_d.rdata = rd_word;
      st_d.rd_err = rd_fault;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.ctrl <= CTRL_INIT;
      st_q.ticks <= TCG_TICKS_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // zero wait states: the access cycle is always the last one
  always_comb begin
    apb_rsp = '0;
    apb_rsp.prdata = st_q.rdata;
    apb_rsp.pready = access_ph;
    apb_rsp.pslverr = access_ph && st_q.rd_err;
  end

  assign count_tick = st_q.tick;
  assign gate_mode_active = gated;

endmodule : tcg_timer_clk_ctrl

// ---- tcg_pkg.sv ----
// package: register map, field positions and carrier types for the timer clock gate
package tcg_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] TCG_CTRL_OFF = 12'h000;
  localparam logic [11:0] TCG_TICKS_OFF = 12'h004;
  localparam logic [11:0] TCG_STAT_OFF = 12'h008;

  // control register field positions
  localparam int TCG_CLK_SRC_BIT = 1;
  localparam int TCG_SYNC_BIT = 2;
  localparam int TCG_PRESC_LO_BIT = 4;
  localparam int TCG_GATE_BIT = 6;

  // implemented control bits; bits 0, 3 and 7 are unimplemented
  localparam logic [7:0] TCG_CTRL_MASK = 8'h76;
  localparam logic [7:0] TCG_CTRL_RESET = 8'h00;
  localparam logic [15:0] TCG_TICKS_RESET = 16'h0000;

  // status register field positions
  localparam int TCG_STAT_EXT_BIT = 0;
  localparam int TCG_STAT_GATE_BIT = 1;
  localparam int TCG_STAT_PEND_BIT = 2;
  localparam int TCG_STAT_PCNT_LO = 8;

  // internal clock is the oscillator divided by two
  localparam int TCG_INT_DIV = 2;

  // prescale ratios
  localparam int TCG_RATIO_1 = 1;
  localparam int TCG_RATIO_8 = 8;
  localparam int TCG_RATIO_64 = 64;
  localparam int TCG_RATIO_256 = 256;

  typedef enum logic [1:0] {
    TCG_PS_1 = 2'b00,
    TCG_PS_8 = 2'b01,
    TCG_PS_64 = 2'b10,
    TCG_PS_256 = 2'b11
  } tcg_presc_t;

  typedef struct packed {
    logic gated_accumulation_enable;
    tcg_presc_t input_prescale_select;
    logic external_clock_sync_select;
    logic clock_source_select;
  } tcg_ctrl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } tcg_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tcg_apb_rsp_t;

endpackage : tcg_pkg

// ---- tcg_sync.sv ----
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module tcg_sync
  import tcg_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // pins from outside the clock domain
  output logic [WIDTH-1:0] sync_out // levels safe to use in the clk domain
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } tcg_sync_st_t;

  tcg_sync_st_t st_q;
  tcg_sync_st_t st_d;

  // the first stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule : tcg_sync

// ---- tcg_timer_clk_ctrl_props.sv ----
// checker: source, gating and prescale properties at the ports
`timescale 1ns/1ps
module tcg_timer_clk_ctrl_props
  import tcg_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire tcg_apb_req_t apb_req, // apb request
  input wire tcg_apb_rsp_t apb_rsp, // apb response
  input wire logic ext_clk_pin, // external clock pin
  input wire logic gate_pin, // gate pin
  input wire logic count_tick, // tick pulse
  input wire logic gate_mode_active // gated mode flag
);
  logic [7:0] c_q;
  logic [9:0] gap_q;
  logic ok_q;
  wire acc = apb_req.psel && apb_req.penable && apb_rsp.pready
    && apb_req.paddr == TCG_CTRL_OFF;
  wire wr = acc && apb_req.pwrite;
  wire gm = c_q[6] && !c_q[1];
  wire i_run = !c_q[1] && !c_q[6];
  // internal clock is osc/2, so a tick gap is twice the ratio
  wire [9:0] per = c_q[5:4] == 2'h3 ? 10'h200 : 10'h002 << (3 * c_q[5:4]);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_q <= 8'h00;
      gap_q <= 10'h000;
      ok_q <= 1'b0;
    end else begin
      if (wr) c_q <= apb_req.pwdata[7:0];
      gap_q <= (count_tick || wr) ? 10'h001 : gap_q + 10'h001;
      // first tick after a write may land at any prescaler phase
      ok_q <= !wr && (ok_q || count_tick);
    end
  end
  a_prescale_gap: assert property (count_tick && ok_q && i_run |-> gap_q == per)
    else $error("tick gap wrong");
  a_tick_pulse: assert property (count_tick |=> !count_tick)
    else $error("tick longer than one cycle");
  a_unimpl_zero: assert property (acc && !apb_req.pwrite |-> (apb_rsp.prdata & 32'h89) == 32'h0)
    else $error("unimplemented bit reads one");
  a_ctrl_back: assert property (acc && !apb_req.pwrite |-> apb_rsp.prdata[7:0] == (c_q & 8'h76))
    else $error("control readback wrong");
  a_gate_on: assert property (gm [*3] |-> gate_mode_active)
    else $error("gated mode missing");
  a_gate_off: assert property (!gm [*3] |-> !gate_mode_active)
    else $error("gated mode unexpected");
  a_gate_hold: assert property ((gate_mode_active && !gate_pin) [*5] |-> !count_tick)
    else $error("tick while gate low");
  a_ext_quiet: assert property ((c_q[1] && $stable(ext_clk_pin)) [*5] |-> !count_tick)
    else $error("tick without external edge");
endmodule : tcg_timer_clk_ctrl_props
bind tcg_timer_clk_ctrl tcg_timer_clk_ctrl_props i_props (.clk(clk), .rst(rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .ext_clk_pin(ext_clk_pin), .gate_pin(gate_pin),
  .count_tick(count_tick), .gate_mode_active(gate_mode_active));

// ---- tcg_timer_clk_ctrl_test.sv ----
// testbench: apb control access and tick counting
`timescale 1ns/1ps
module tcg_timer_clk_ctrl_test;
  import tcg_pkg::*;
  logic clk, rst, ext_clk_pin, gate_pin, count_tick, gate_mode_active;
  tcg_apb_req_t rq;
  tcg_apb_rsp_t rs;
  int err_total, n_compared, cyc, ticks, t0;
  logic [31:0] rd_v;
  logic err_v;
  tcg_timer_clk_ctrl i_tcg_timer_clk_ctrl (.clk(clk), .rst(rst), .apb_req(rq), .apb_rsp(rs),
    .ext_clk_pin(ext_clk_pin), .gate_pin(gate_pin), .count_tick(count_tick),
    .gate_mode_active(gate_mode_active));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    rq <= '{1'b1, 1'b0, w, a, d, {4{w}}};
    @(posedge clk);
    rq.penable <= 1'b1;
    do @(posedge clk); while (rs.pready !== 1'b1);
    rd_v = rs.prdata;
    err_v = rs.pslverr;
    rq <= '0;
    @(posedge clk);
  endtask : xfer
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (count_tick === 1'b1) ticks <= ticks + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    {rst, ext_clk_pin, gate_pin, cyc, ticks, err_total, n_compared} = '0;
    rst = 1'b1;
    rq = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(0, TCG_CTRL_OFF, 0);
    chk(rd_v, 32'h0);
    xfer(1, TCG_CTRL_OFF, 32'hff);
    xfer(0, TCG_CTRL_OFF, 0);
    chk(rd_v, 32'h76);
    xfer(0, 12'hffc, 0);
    chk(err_v, 1);
    $display("test readback done");
    // sync bit set in internal mode and gate pin moving: neither may disturb the gap
    for (int k = 0; k < 4; k++) begin
      xfer(1, TCG_CTRL_OFF, {26'h0, k[1:0], 4'h4});
      repeat (1200) begin
        @(posedge clk);
        gate_pin <= ~gate_pin;
      end
    end
    $display("test prescale done");
    xfer(1, TCG_CTRL_OFF, 32'h40);
    gate_pin <= 1'b0;
    repeat (20) @(posedge clk);
    t0 = ticks;
    repeat (40) @(posedge clk);
    chk(ticks - t0, 0);
    chk(gate_mode_active, 1);
    gate_pin <= 1'b1;
    t0 = ticks;
    repeat (40) @(posedge clk);
    chk(ticks - t0 >= 17, 1);
    xfer(0, TCG_STAT_OFF, 0);
    chk(rd_v, 32'h2);
    $display("test gated done");
    for (int s = 0; s < 2; s++) begin
      xfer(1, TCG_CTRL_OFF, 32'h42 | (s << 2));
      gate_pin <= 1'b0;
      repeat (10) @(posedge clk);
      t0 = ticks;
      repeat (16) begin
        repeat (3) @(posedge clk);
        ext_clk_pin <= 1'b1;
        repeat (3) @(posedge clk);
        ext_clk_pin <= 1'b0;
      end
      repeat (10) @(posedge clk);
      chk(ticks - t0, 16);
      chk(gate_mode_active, 0);
    end
    xfer(0, TCG_TICKS_OFF, 0);
    chk(rd_v, ticks);
    $display("test external done");
    conclude();
  end
endmodule : tcg_timer_clk_ctrl_test
